// File: core/lpg_mode_resolve.sv
// Module that redirects a requested power mode under debug or low-voltage stop.
`timescale 1ns/10ps
module lpg_mode_resolve
   import lpg_pkg::*;
(
   input  wire logic [2:0] req,
   input  wire logic       debug_enable_flag,
   input  wire logic       lowvolt_stop_enable,
   output      logic [2:0] mode
);
   logic block_lp;
   assign block_lp = debug_enable_flag | lowvolt_stop_enable;
   always_comb begin
      unique case (req)
         // RULE4 RULE6 deep stop redirect.
         LPG_REQ_DSTOP:  mode = block_lp ? LPG_LSTOP : LPG_DSTOP;
         // RULE5 RULE7 low-power run redirect.
         LPG_REQ_LOW_POWER_RUN_MODE:  mode = block_lp ? LPG_RUN : LPG_LOW_POWER_RUN_MODE;
         LPG_REQ_LOW_POWER_WAIT_MODE: mode = block_lp ? LPG_WAIT : LPG_LOW_POWER_WAIT_MODE;
         LPG_REQ_LSTOP:  mode = LPG_LSTOP;
         LPG_REQ_WAIT:   mode = LPG_WAIT;
         default:        mode = LPG_RUN;
      endcase
   end
endmodule : lpg_mode_resolve

// File: core/lpg_pkg.sv
// Package with register map, field positions and mode encodings for the peripheral gating block.
// Overview of operation
// RULE1: Any stop mode halts all peripheral clocks.
// RULE2: Debug flag keeps debug clock in stop.
// RULE3: Low-power modes gate clocks per gating registers.
// RULE4: Debug flag turns deep stop into light stop.
// RULE5: Debug flag keeps normal run or wait.
// RULE6: Low-voltage stop turns deep into light stop.
// RULE7: Low-voltage stop keeps normal run or wait.
// RULE8: Software sets bypass mode, bus at most 125kHz.
// RULE9: Light stop keeps internal reference only if enabled.
// RULE10: Stop keeps crystal oscillator only if enabled.
// RULE11: Low-power time counter needs slow clock source.
// RULE12: Low-power display needs oscillator or time clock.
// RULE13: Light stop regulator on only with detection.
// RULE14: Converter uses async clock; reference for bandgap.
// RULE15: Software enables reference for comparator bandgap.
package lpg_pkg;
   localparam logic [11:0] LPG_ADDR_CTRL   = 12'h000;
   localparam logic [11:0] LPG_ADDR_GATE1  = 12'h004;
   localparam logic [11:0] LPG_ADDR_GATE2  = 12'h008;
   localparam logic [11:0] LPG_ADDR_CLKGEN = 12'h00C;
   localparam logic [11:0] LPG_ADDR_REQ    = 12'h010;
   localparam logic [11:0] LPG_ADDR_STATUS = 12'h014;

   localparam int LPG_CTRL_DEBUG    = 0;
   localparam int LPG_CTRL_LVSTOP   = 1;
   localparam int LPG_CTRL_LVDET    = 2;
   localparam int LPG_CTRL_TODSRC   = 4;
   localparam int LPG_CTRL_DISPSRC  = 6;
   localparam int LPG_CTRL_ADCASYNC = 8;
   localparam int LPG_CTRL_VREFSTOP = 9;
   localparam int LPG_CTRL_ADCBG    = 10;
   localparam int LPG_CTRL_ACMPBG   = 11;
   localparam int LPG_CLK_INTERNAL_REF_CLOCK_ENABLE   = 0;
   localparam int LPG_CLK_IRSTEN    = 1;
   localparam int LPG_CLK_EXTERNAL_REF_CLOCK_ENABLE   = 2;
   localparam int LPG_CLK_ERSTEN    = 3;
   localparam int LPG_CLK_BYPASS    = 4;

   localparam logic [1:0] LPG_TOD_LPO     = 2'h0;
   localparam logic [1:0] LPG_TOD_OSCILLATOR_OUTPUT_CLOCK  = 2'h1;
   localparam logic [1:0] LPG_DISP_OSCILLATOR_OUTPUT_CLOCK = 2'h0;
   localparam logic [1:0] LPG_DISP_TIME_OF_DAY_CLOCK = 2'h1;

   localparam logic [31:0] LPG_CTRL_RESET  = 32'h00000000;
   localparam logic [31:0] LPG_GATE_RESET  = 32'h000000FF;
   localparam logic [31:0] LPG_CLK_RESET   = 32'h00000000;
   localparam int          LPG_GATE_W      = 8;

   typedef enum logic [2:0] {
      LPG_REQ_RUN    = 3'h0,
      LPG_REQ_WAIT   = 3'h1,
      LPG_REQ_LOW_POWER_RUN_MODE  = 3'h2,
      LPG_REQ_LOW_POWER_WAIT_MODE = 3'h3,
      LPG_REQ_LSTOP  = 3'h4,
      LPG_REQ_DSTOP  = 3'h5
   } lpg_req_type;

   typedef enum logic [2:0] {
      LPG_RUN    = 3'b000,
      LPG_WAIT   = 3'b001,
      LPG_LOW_POWER_RUN_MODE  = 3'b011,
      LPG_LOW_POWER_WAIT_MODE = 3'b010,
      LPG_LSTOP  = 3'b110,
      LPG_DSTOP  = 3'b111
   } lpg_mode_type;
endpackage : lpg_pkg

// File: core/lpg_top.sv
// Top module of the peripheral clock and domain gating block with its APB slave.
`timescale 1ns/10ps
module lpg_top
   import lpg_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output      logic [31:0]           prdata,
   output      logic                  pready,
   output      logic                  pslverr,
   output      logic [LPG_GATE_W-1:0] periph_clk_en_one,
   output      logic [LPG_GATE_W-1:0] periph_clk_en_two,
   output      logic                  debug_clk_en,
   output      logic                  internal_ref_run,
   output      logic                  crystal_osc_run,
   output      logic                  regulator_full_on,
   output      logic                  regulator_partial_down,
   output      logic                  tod_run,
   output      logic                  display_run,
   output      logic                  converter_run,
   output      logic                  comparator_run,
   output      logic [2:0]            mode_state
);
   logic [31:0]           ctrl_reg;
   logic [LPG_GATE_W-1:0] gate1_reg;
   logic [LPG_GATE_W-1:0] gate2_reg;
   logic [4:0]            clkgen_reg;
   logic [2:0]            req_reg;
   logic [2:0]            mode_next;
   logic                  wr_en;
   logic                  addr_ok;
   logic                  in_stop;
   logic                  in_lp;
   logic                  debug_enable_flag;
   logic                  lowvolt_stop_enable;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == LPG_ADDR_CTRL) || (a == LPG_ADDR_GATE1) || (a == LPG_ADDR_GATE2) ||
                  (a == LPG_ADDR_CLKGEN) || (a == LPG_ADDR_REQ) || (a == LPG_ADDR_STATUS);
   endfunction : is_mapped

   assign addr_ok             = is_mapped(paddr);
   assign wr_en               = psel & penable & pwrite & addr_ok;
   assign debug_enable_flag   = ctrl_reg[LPG_CTRL_DEBUG];
   assign lowvolt_stop_enable = ctrl_reg[LPG_CTRL_LVSTOP];
   assign in_stop = (mode_state == LPG_LSTOP) || (mode_state == LPG_DSTOP);
   assign in_lp   = (mode_state == LPG_LOW_POWER_RUN_MODE) || (mode_state == LPG_LOW_POWER_WAIT_MODE);

   lpg_mode_resolve u_resolve (
      .req                 (req_reg),
      .debug_enable_flag   (debug_enable_flag),
      .lowvolt_stop_enable (lowvolt_stop_enable),
      .mode                (mode_next)
   );

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_reg   <= LPG_CTRL_RESET;
         gate1_reg  <= LPG_GATE_RESET[LPG_GATE_W-1:0];
         gate2_reg  <= LPG_GATE_RESET[LPG_GATE_W-1:0];
         clkgen_reg <= LPG_CLK_RESET[4:0];
         req_reg    <= LPG_REQ_RUN;
      end else if (wr_en) begin
         unique case (paddr)
            LPG_ADDR_CTRL:   ctrl_reg   <= pwdata;
            LPG_ADDR_GATE1:  gate1_reg  <= pwdata[LPG_GATE_W-1:0];
            LPG_ADDR_GATE2:  gate2_reg  <= pwdata[LPG_GATE_W-1:0];
            LPG_ADDR_CLKGEN: clkgen_reg <= pwdata[4:0];
            LPG_ADDR_REQ:    req_reg    <= (pwdata[2:0] > LPG_REQ_DSTOP) ? LPG_REQ_RUN
                                                                           : pwdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (psel & ~penable & ~pwrite) begin
            unique case (paddr)
               LPG_ADDR_CTRL:   prdata <= ctrl_reg;
               LPG_ADDR_GATE1:  prdata <= {24'h000000, gate1_reg};
               LPG_ADDR_GATE2:  prdata <= {24'h000000, gate2_reg};
               LPG_ADDR_CLKGEN: prdata <= {27'h0000000, clkgen_reg};
               LPG_ADDR_REQ:    prdata <= {29'h00000000, req_reg};
               LPG_ADDR_STATUS: prdata <= {29'h00000000, mode_state};
               default:         prdata <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_state <= LPG_RUN;
      end else begin
         mode_state <= mode_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         periph_clk_en_one <= '1;
         periph_clk_en_two <= '1;
         debug_clk_en      <= 1'b1;
      end else if (mode_next == LPG_LSTOP || mode_next == LPG_DSTOP) begin
         // RULE1 stop halts clocks.
         periph_clk_en_one <= '0;
         periph_clk_en_two <= '0;
         // RULE2 debug clock kept.
         debug_clk_en      <= debug_enable_flag;
      end else if (mode_next == LPG_LOW_POWER_RUN_MODE || mode_next == LPG_LOW_POWER_WAIT_MODE) begin
         // RULE3 register-driven gating.
         periph_clk_en_one <= gate1_reg;
         periph_clk_en_two <= gate2_reg;
         debug_clk_en      <= 1'b0;
      end else begin
         periph_clk_en_one <= '1;
         periph_clk_en_two <= '1;
         debug_clk_en      <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         internal_ref_run       <= 1'b1;
         crystal_osc_run        <= 1'b1;
         regulator_full_on      <= 1'b1;
         regulator_partial_down <= 1'b0;
      end else begin
         // RULE9 internal reference in light stop.
         internal_ref_run <= (mode_next == LPG_DSTOP) ? 1'b0 :
                             (mode_next == LPG_LSTOP) ? (clkgen_reg[LPG_CLK_INTERNAL_REF_CLOCK_ENABLE] &
                                                         clkgen_reg[LPG_CLK_IRSTEN]) : 1'b1;
         // RULE10 crystal oscillator in stop.
         crystal_osc_run  <= (mode_next == LPG_LSTOP || mode_next == LPG_DSTOP) ?
                             (clkgen_reg[LPG_CLK_EXTERNAL_REF_CLOCK_ENABLE] & clkgen_reg[LPG_CLK_ERSTEN]) : 1'b1;
         // RULE13 regulator in light stop.
         regulator_full_on <= (mode_next == LPG_LSTOP) ? ctrl_reg[LPG_CTRL_LVDET] :
                              (mode_next == LPG_RUN || mode_next == LPG_WAIT);
         regulator_partial_down <= (mode_next == LPG_DSTOP);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         tod_run        <= 1'b1;
         display_run    <= 1'b1;
         converter_run  <= 1'b1;
         comparator_run <= 1'b1;
      end else if (in_lp) begin
         // RULE11 slow time-of-day source.
         tod_run <= (ctrl_reg[LPG_CTRL_TODSRC+:2] == LPG_TOD_LPO) ||
                    (ctrl_reg[LPG_CTRL_TODSRC+:2] == LPG_TOD_OSCILLATOR_OUTPUT_CLOCK);
         // RULE12 display clock source.
         display_run <= (ctrl_reg[LPG_CTRL_DISPSRC+:2] == LPG_DISP_OSCILLATOR_OUTPUT_CLOCK) ||
                        (ctrl_reg[LPG_CTRL_DISPSRC+:2] == LPG_DISP_TIME_OF_DAY_CLOCK);
         // RULE14 converter asynchronous clock.
         converter_run  <= ctrl_reg[LPG_CTRL_ADCASYNC];
         comparator_run <= 1'b1;
      end else if (in_stop) begin
         tod_run     <= 1'b1;
         display_run <= 1'b1;
         // RULE14 converter bandgap reference.
         converter_run <= (mode_state == LPG_LSTOP) & ctrl_reg[LPG_CTRL_ADCASYNC] &
                          (~ctrl_reg[LPG_CTRL_ADCBG] | ctrl_reg[LPG_CTRL_VREFSTOP]);
         // RULE15 comparator bandgap reference.
         comparator_run <= (mode_state == LPG_LSTOP) &
                           (~ctrl_reg[LPG_CTRL_ACMPBG] | ctrl_reg[LPG_CTRL_VREFSTOP]);
      end else begin
         tod_run        <= 1'b1;
         display_run    <= 1'b1;
         converter_run  <= 1'b1;
         comparator_run <= 1'b1;
      end
   end
endmodule : lpg_top

// File: verification/lpg_monitor.sv
// Checker of the gating block's port behaviour.
`timescale 1ns/10ps
module lpg_monitor
   import lpg_pkg::*;
(
   input wire logic                  mclk,
   input wire logic                  reset,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic [LPG_GATE_W-1:0] periph_clk_en_one,
   input wire logic [LPG_GATE_W-1:0] periph_clk_en_two,
   input wire logic                  debug_clk_en,
   input wire logic                  internal_ref_run,
   input wire logic                  regulator_full_on,
   input wire logic                  regulator_partial_down,
   input wire logic [2:0]            mode_state
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   property p_stop_gate;
      mode_state[2] |-> (periph_clk_en_one == '0) && (periph_clk_en_two == '0);
   endproperty
   a_stop_gate: assert property (p_stop_gate) else $error("Clocks run in stop.");
   property p_dstop_dbg;
      mode_state == LPG_DSTOP |-> !debug_clk_en && !internal_ref_run;
   endproperty
   a_dstop_dbg: assert property (p_dstop_dbg) else $error("Deep stop keeps clocks.");
   property p_dstop_reg;
      mode_state == LPG_DSTOP |-> regulator_partial_down && !regulator_full_on;
   endproperty
   a_dstop_reg: assert property (p_dstop_reg) else $error("Regulator state wrong.");
   property p_lp_dbg;
      mode_state[2:1] == 2'b01 |-> !debug_clk_en;
   endproperty
   a_lp_dbg: assert property (p_lp_dbg) else $error("Debug clock in low power.");
   property p_run_req;
      psel && penable && pready && pwrite && paddr == LPG_ADDR_REQ && pwdata[2:0] == 3'h0
         |-> ##[1:2] mode_state == LPG_RUN;
   endproperty
   a_run_req: assert property (p_run_req) else $error("Run request ignored.");
   property p_ack;
      psel && !penable |=> pready;
   endproperty
   a_ack: assert property (p_ack) else $error("No ready in access phase.");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("Ready longer than a cycle.");
   property p_err;
      pslverr |-> pready && $past(psel) && !$past(penable);
   endproperty
   a_err: assert property (p_err) else $error("Error outside access.");
   c_lstop: cover property (mode_state == LPG_LSTOP);
   c_low_power_wait_mode: cover property (mode_state == LPG_LOW_POWER_WAIT_MODE);
   c_err: cover property (pslverr);
endmodule : lpg_monitor
bind lpg_top lpg_monitor lpg_monitor_inst (
   .mclk                   (mclk),
   .reset                  (reset),
   .psel                   (psel),
   .penable                (penable),
   .pwrite                 (pwrite),
   .paddr                  (paddr),
   .pwdata                 (pwdata),
   .pready                 (pready),
   .pslverr                (pslverr),
   .periph_clk_en_one      (periph_clk_en_one),
   .periph_clk_en_two      (periph_clk_en_two),
   .debug_clk_en           (debug_clk_en),
   .internal_ref_run       (internal_ref_run),
   .regulator_full_on      (regulator_full_on),
   .regulator_partial_down (regulator_partial_down),
   .mode_state             (mode_state)
);

// File: verification/lpg_periph_model.sv
// Model of the peripheral clock gates counting delivered clock ticks.
`timescale 1ns/10ps
module lpg_periph_model
   import lpg_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic [LPG_GATE_W-1:0] gate_one,
   input  wire logic [LPG_GATE_W-1:0] gate_two,
   output      logic [15:0]           ticks
);
   logic [15:0] count_reg = 16'h0000;
   assign ticks = count_reg;
   always_ff @(posedge mclk) begin
      count_reg <= count_reg + 16'((gate_one != '0) || (gate_two != '0));
   end
endmodule : lpg_periph_model

// File: verification/testbench.sv
// Self-checking testbench of the peripheral gating block.
`timescale 1ns/10ps
module testbench
   import lpg_pkg::*;
;
   logic        mclk, reset, psel, penable, pwrite, pready, pslverr, err, red, hung;
   logic        tod_run, display_run, converter_run, comparator_run, regulator_partial_down;
   logic        debug_clk_en, internal_ref_run, crystal_osc_run, regulator_full_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, g1, g2, ck, ctl;
   logic [7:0]  periph_clk_en_one, periph_clk_en_two;
   logic [2:0]  mode_state, em;
   logic [15:0] ticks, t0;
   int          miscompares, checks_done, n;
   lpg_top lpg_top_inst (
      .mclk                   (mclk),
      .reset                  (reset),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .prdata                 (prdata),
      .pready                 (pready),
      .pslverr                (pslverr),
      .periph_clk_en_one      (periph_clk_en_one),
      .periph_clk_en_two      (periph_clk_en_two),
      .debug_clk_en           (debug_clk_en),
      .internal_ref_run       (internal_ref_run),
      .crystal_osc_run        (crystal_osc_run),
      .regulator_full_on      (regulator_full_on),
      .regulator_partial_down (regulator_partial_down),
      .tod_run                (tod_run),
      .display_run            (display_run),
      .converter_run          (converter_run),
      .comparator_run         (comparator_run),
      .mode_state             (mode_state)
   );
   lpg_periph_model lpg_periph_model_inst (.mclk(mclk), .gate_one(periph_clk_en_one),
      .gate_two(periph_clk_en_two), .ticks(ticks));
   task give_verdict;
      if (miscompares == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         hung = 1'b1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [2:0] exp_mode(int r, bit rd_on);
      case (r)
         1: return LPG_WAIT;
         2: return rd_on ? LPG_RUN : LPG_LOW_POWER_RUN_MODE;
         3: return rd_on ? LPG_WAIT : LPG_LOW_POWER_WAIT_MODE;
         4: return LPG_LSTOP;
         5: return rd_on ? LPG_LSTOP : LPG_DSTOP;
         default: return LPG_RUN;
      endcase
   endfunction : exp_mode
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h000, 32'h0};
      seed = 32'h3AF8;
      hung = 1'b0;
      miscompares = 0;
      checks_done = 0;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      apb(1'b0, LPG_ADDR_GATE1, 32'h0);
      check(rd, LPG_GATE_RESET);
      apb(1'b0, 12'h020, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b1, LPG_ADDR_REQ, 32'h7);
      apb(1'b0, LPG_ADDR_STATUS, 32'h0);
      check(rd, {29'h0, LPG_RUN});
      for (int i = 0; i < 24 && !hung; i++) begin
         g1 = $random(seed) & 32'hFF;
         g2 = $random(seed) & 32'hFF;
         ck = ($random(seed) & 32'hF) | 32'h10;
         ctl = {20'h0, 8'($random(seed)), 1'b0, 1'($random(seed)), i[1:0]};
         red = (i[1:0] != 2'b00);
         apb(1'b1, LPG_ADDR_GATE1, g1);
         apb(1'b1, LPG_ADDR_GATE2, g2);
         apb(1'b1, LPG_ADDR_CLKGEN, ck);
         apb(1'b1, LPG_ADDR_CTRL, ctl);
         apb(1'b1, LPG_ADDR_REQ, i / 4);
         em = exp_mode(i / 4, red);
         repeat (3) @(posedge mclk);
         apb(1'b0, LPG_ADDR_STATUS, 32'h0);
         check(rd, {29'h0, em});
         check({29'h0, mode_state}, {29'h0, em});
         if (em[2]) begin
            t0 = ticks;
            repeat (2) @(posedge mclk);
            check({16'h0, ticks}, {16'h0, t0});
            check({31'h0, debug_clk_en}, {31'h0, ctl[0]});
            check({31'h0, crystal_osc_run}, {31'h0, ck[2] & ck[3]});
            check({31'h0, regulator_partial_down}, {31'h0, em == LPG_DSTOP});
         end
         if (em == LPG_DSTOP) begin
            check({30'h0, converter_run, comparator_run}, 32'h0);
         end
         if (em == LPG_LSTOP) begin
            check({31'h0, internal_ref_run}, {31'h0, ck[0] & ck[1]});
            check({31'h0, regulator_full_on}, {31'h0, ctl[2]});
            check({31'h0, converter_run}, {31'h0, ctl[8] & (~ctl[10] | ctl[9])});
            check({31'h0, comparator_run}, {31'h0, ~ctl[11] | ctl[9]});
         end
         if (em[2:1] == 2'b01) begin
            check({16'h0, periph_clk_en_two, periph_clk_en_one}, {16'h0, g2[7:0], g1[7:0]});
            check({31'h0, tod_run}, {31'h0, ctl[5:4] < 2'h2});
            check({31'h0, display_run}, {31'h0, ctl[7:6] < 2'h2});
            check({31'h0, converter_run}, {31'h0, ctl[8]});
         end
         if (em[2:1] == 2'b00) begin
            check({16'h0, periph_clk_en_two, periph_clk_en_one}, 32'h0000FFFF);
            check({31'h0, debug_clk_en}, 32'h1);
            check({30'h0, internal_ref_run, crystal_osc_run}, 32'h3);
         end
      end
      give_verdict;
   end
endmodule : testbench
